// ---- hdl/crcp_byte_step.sv ----
`timescale 1ns/1ps
// one byte folded into the checksum, msb first
module crcp_byte_step (
    input wire logic [31:0] crc_in,
    input wire logic [7:0] data_in,
    input wire logic [31:0] poly,
    input wire logic wide,
    output logic [31:0] crc_out
);
    always_comb begin
        logic [31:0] c;
        logic fb;
        c = crc_in;
        fb = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            fb = (wide ? c[31] : c[15]) ^ data_in[i];
            c = {c[30:0], 1'b0} ^ (fb ? poly : 32'h0000_0000);
            if (!wide) begin
                c = c & crcp_pkg::CRCP_MASK_16;
            end
        end
        crc_out = c;
    end
endmodule

// ---- hdl/crcp_out_fmt.sv ----
`timescale 1ns/1ps
// result presentation: optional reversal and complement
module crcp_out_fmt (
    input wire logic [31:0] acc,
    input wire logic wide,
    input wire logic rev,
    input wire logic cmp,
    output logic [31:0] sum
);
    logic [31:0] rev32;
    logic [15:0] rev16;
    logic [31:0] ordered;
    logic [31:0] mask;

    genvar i;
    generate
        for (i = 0; i < 32; i++) begin : g_r32
            assign rev32[i] = acc[31 - i];
        end
        for (i = 0; i < 16; i++) begin : g_r16
            assign rev16[i] = acc[15 - i];
        end
    endgenerate

    assign mask = wide ? crcp_pkg::CRCP_MASK_32 : crcp_pkg::CRCP_MASK_16;
    // [RULE_02] output bit reversal
    assign ordered = rev ? (wide ? rev32 : {16'h0000, rev16}) : (acc & mask);
    // [RULE_03] output complement
    assign sum = cmp ? (ordered ^ mask) : ordered;
endmodule

// ---- hdl/crcp_pkg.sv ----
package crcp_pkg;

    // register byte offsets
    localparam logic [7:0] CRCP_MODE_OFS = 8'h00;
    localparam logic [7:0] CRCP_SEED_OFS = 8'h04;
    localparam logic [7:0] CRCP_SUM_OFS = 8'h08;
    localparam logic [7:0] CRCP_DATA_OFS = 8'h0c;
    localparam logic [7:0] CRCP_POLY_OFS = 8'h10;
    localparam logic [7:0] CRCP_STAT_OFS = 8'h14;
    localparam logic [7:0] CRCP_CNT_OFS = 8'h18;

    // mode register fields
    localparam int CRCP_MODE_W = 7;
    localparam int CRCP_SEL_LSB = 0;
    localparam int CRCP_IN_REV_BIT = 2;
    localparam int CRCP_IN_CMP_BIT = 3;
    localparam int CRCP_OUT_REV_BIT = 4;
    localparam int CRCP_OUT_CMP_BIT = 5;
    localparam int CRCP_PROG16_BIT = 6;

    // status register fields
    localparam int CRCP_BUSY_BIT = 0;
    localparam int CRCP_LEFT_LSB = 1;

    // reset values
    localparam logic [6:0] CRCP_MODE_RST = 7'h00;
    localparam logic [31:0] CRCP_SEED_RST = 32'h0000_0000;
    localparam logic [31:0] CRCP_POLY_RST = 32'h04c1_1db7;
    localparam logic [31:0] CRCP_CNT_RST = 32'h0000_0000;

    // fixed generator polynomials, top term implied
    localparam logic [31:0] CRCP_POLY_CCITT = 32'h0000_1021;
    localparam logic [31:0] CRCP_POLY_16 = 32'h0000_8005;
    localparam logic [31:0] CRCP_POLY_32 = 32'h04c1_1db7;

    // result masks per width
    localparam logic [31:0] CRCP_MASK_16 = 32'h0000_ffff;
    localparam logic [31:0] CRCP_MASK_32 = 32'hffff_ffff;

    // bytes still to absorb after the accepting cycle
    localparam logic [1:0] CRCP_LEFT_BYTE = 2'h0;
    localparam logic [1:0] CRCP_LEFT_HALF = 2'h1;
    localparam logic [1:0] CRCP_LEFT_WORD = 2'h3;

    typedef enum logic [1:0] {
        CRCP_SEL_CCITT,
        CRCP_SEL_16,
        CRCP_SEL_32,
        CRCP_SEL_PROG
    } crcp_sel_t;

endpackage

// ---- hdl/crcp_top.sv ----
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// Contract
// [RULE_01] three fixed polynomials: ccitt, crc16, crc32
// [RULE_02] separate bit reversal for input and result
// [RULE_03] separate complement for input and result
// [RULE_04] software loads a starting seed
// [RULE_05] data writes of 8, 16, 32 bits
// [RULE_06] byte write absorbed in one cycle
// [RULE_07] halfword write takes two byte cycles
// [RULE_08] word write takes four byte cycles
// [RULE_09] back to back writes without gaps; multi-byte writes stall the next access until drained plus one cycle
// [RULE_10] software programmable generator polynomial
// [RULE_11] seed restarts; result read after formatting
module crcp_top (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic crc_busy
);

    // bit reversal within one byte
    function automatic logic [7:0] rev8(input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        for (int k = 0; k < 8; k++) begin
            r[k] = b[7 - k];
        end
        return r;
    endfunction

    // lowest enabled lane of a legal strobe
    function automatic logic [1:0] lane_of(input logic [3:0] s);
        logic [1:0] l;
        l = 2'h0;
        if (s == 4'h2) begin
            l = 2'h1;
        end else if (s == 4'h4 || s == 4'hc) begin
            l = 2'h2;
        end else if (s == 4'h8) begin
            l = 2'h3;
        end
        return l;
    endfunction

    // bytes left after the first, per strobe
    function automatic logic [1:0] left_of(input logic [3:0] s);
        logic [1:0] n;
        n = crcp_pkg::CRCP_LEFT_BYTE;
        if (s == 4'h3 || s == 4'hc) begin
            n = crcp_pkg::CRCP_LEFT_HALF;
        end else if (s == 4'hf) begin
            n = crcp_pkg::CRCP_LEFT_WORD;
        end
        return n;
    endfunction

    // strobe forms a byte, aligned halfword or word
    function automatic logic strb_legal(input logic [3:0] s);
        return (s == 4'h1) || (s == 4'h2) || (s == 4'h4) || (s == 4'h8) ||
            (s == 4'h3) || (s == 4'hc) || (s == 4'hf);
    endfunction

    logic [6:0] mode_r;
    logic [6:0] mode_nxt;
    logic [31:0] poly_r;
    logic [31:0] poly_nxt;
    logic [31:0] acc_r;
    logic [31:0] acc_nxt;
    logic [23:0] queue_r;
    logic [23:0] queue_nxt;
    logic [1:0] left_r;
    logic [1:0] left_nxt;
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic gate_r;
    logic gate_nxt;

    // address decode
    wire hit_mode = (paddr == crcp_pkg::CRCP_MODE_OFS);
    wire hit_seed = (paddr == crcp_pkg::CRCP_SEED_OFS);
    wire hit_sum = (paddr == crcp_pkg::CRCP_SUM_OFS);
    wire hit_data = (paddr == crcp_pkg::CRCP_DATA_OFS);
    wire hit_poly = (paddr == crcp_pkg::CRCP_POLY_OFS);
    wire hit_stat = (paddr == crcp_pkg::CRCP_STAT_OFS);
    wire hit_cnt = (paddr == crcp_pkg::CRCP_CNT_OFS);
    wire hit_any = hit_mode | hit_seed | hit_sum | hit_data | hit_poly | hit_stat | hit_cnt;
    wire size_ok = strb_legal(pstrb);
    wire bad_acc = ~hit_any | (pwrite & hit_data & ~size_ok);

    // handshake
    wire busy = (left_r != crcp_pkg::CRCP_LEFT_BYTE);
    wire access = psel & penable;
    // [RULE_09] stall while earlier bytes drain and for one cycle after
    assign pready = access & gate_r & ~busy;
    assign pslverr = pready & bad_acc;
    wire xfer_ok = pready & ~bad_acc;
    wire wr_ok = xfer_ok & pwrite;

    // mode fields
    wire [1:0] sel_raw = mode_r[crcp_pkg::CRCP_SEL_LSB +: 2];
    wire in_rev = mode_r[crcp_pkg::CRCP_IN_REV_BIT];
    wire in_cmp = mode_r[crcp_pkg::CRCP_IN_CMP_BIT];
    wire out_rev = mode_r[crcp_pkg::CRCP_OUT_REV_BIT];
    wire out_cmp = mode_r[crcp_pkg::CRCP_OUT_CMP_BIT];
    wire prog16 = mode_r[crcp_pkg::CRCP_PROG16_BIT];
    wire is_ccitt = (sel_raw == crcp_pkg::CRCP_SEL_CCITT);
    wire is_16 = (sel_raw == crcp_pkg::CRCP_SEL_16);
    wire is_32 = (sel_raw == crcp_pkg::CRCP_SEL_32);
    wire is_prog = (sel_raw == crcp_pkg::CRCP_SEL_PROG);

    // [RULE_01] fixed polynomial choice
    wire [31:0] poly_fix = is_ccitt ? crcp_pkg::CRCP_POLY_CCITT :
        (is_16 ? crcp_pkg::CRCP_POLY_16 : crcp_pkg::CRCP_POLY_32);
    // [RULE_10] programmable polynomial path
    wire [31:0] poly_use = is_prog ? poly_r : poly_fix;
    wire wide = is_32 | (is_prog & ~prog16);
    wire [31:0] width_mask = wide ? crcp_pkg::CRCP_MASK_32 : crcp_pkg::CRCP_MASK_16;

    // [RULE_05] width taken from byte strobes
    wire data_go = wr_ok & hit_data;
    wire [1:0] lane = lane_of(pstrb);
    wire [31:0] data_sh = pwdata >> {lane, 3'b000};

    // [RULE_06] first byte absorbed on the accepting edge
    wire [7:0] byte_raw = data_go ? data_sh[7:0] : queue_r[7:0];
    // [RULE_02] input bit reversal
    wire [7:0] byte_ord = in_rev ? rev8(byte_raw) : byte_raw;
    // [RULE_03] input complement
    wire [7:0] byte_use = in_cmp ? ~byte_ord : byte_ord;
    wire step_en = data_go | busy;

    logic [31:0] step_out;
    logic [31:0] sum;

    crcp_byte_step u_step (
        .crc_in(acc_r),
        .data_in(byte_use),
        .poly(poly_use),
        .wide(wide),
        .crc_out(step_out)
    );

    // [RULE_11] result formatted on read
    crcp_out_fmt u_fmt (
        .acc(acc_r),
        .wide(wide),
        .rev(out_rev),
        .cmp(out_cmp),
        .sum(sum)
    );

    // register writes
    assign mode_nxt = (wr_ok & hit_mode) ? pwdata[crcp_pkg::CRCP_MODE_W - 1:0] : mode_r;
    assign poly_nxt = (wr_ok & hit_poly) ? pwdata : poly_r;

    // [RULE_04] seed load into the accumulator
    wire seed_go = wr_ok & hit_seed;
    // [RULE_11] seed restarts the computation
    assign acc_nxt = seed_go ? (pwdata & width_mask) : (step_en ? step_out : acc_r);

    // [RULE_07] remaining bytes queued, one per cycle
    assign queue_nxt = data_go ? data_sh[31:8] : (busy ? {8'h00, queue_r[23:8]} : queue_r);
    // [RULE_08] word leaves three more byte cycles
    assign left_nxt = data_go ? left_of(pstrb) : (busy ? left_r - 2'h1 : left_r);

    // absorbed byte count, restarted by a seed
    assign cnt_nxt = seed_go ? crcp_pkg::CRCP_CNT_RST :
        (step_en ? cnt_r + 32'h0000_0001 : cnt_r);

    // ready given only in the cycle after one with psel high and no bytes draining, so a read sees a settled sum
    assign gate_nxt = psel & ~busy;
    wire [31:0] stat_val = {29'h0000_0000, left_r, busy};
    assign rdata_nxt = hit_mode ? {25'h000_0000, mode_r} :
        hit_seed ? 32'h0000_0000 :
        hit_sum ? sum :
        hit_poly ? poly_r :
        hit_stat ? stat_val :
        hit_cnt ? cnt_r : 32'h0000_0000;

    assign prdata = rdata_r;
    assign crc_busy = busy;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_r <= crcp_pkg::CRCP_MODE_RST;
            poly_r <= crcp_pkg::CRCP_POLY_RST;
            acc_r <= crcp_pkg::CRCP_SEED_RST;
        end else begin
            mode_r <= mode_nxt;
            poly_r <= poly_nxt;
            acc_r <= acc_nxt;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            queue_r <= 24'h00_0000;
            left_r <= crcp_pkg::CRCP_LEFT_BYTE;
            cnt_r <= crcp_pkg::CRCP_CNT_RST;
        end else begin
            queue_r <= queue_nxt;
            left_r <= left_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 32'h0000_0000;
            gate_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            gate_r <= gate_nxt;
        end
    end

endmodule

// ---- verification/crcp_apb_master.sv ----
`timescale 1ns/1ps
module crcp_apb_master (
    input wire logic clk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [7:0] paddr = 8'h00,
    output logic [31:0] pwdata = 32'h0000_0000,
    output logic [3:0] pstrb = 4'h0
);
    bit hold = 1'b0;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s, input bit more, output logic [31:0] r, output logic e);
        if (!hold) psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        penable <= 1'b0;
        hold = more;
        if (!more) begin
            psel <= 1'b0;
            paddr <= ~a;
            pwdata <= ~d;
            @(posedge clk);
        end
    endtask
endmodule

// ---- verification/crcp_top_bench.sv ----
`timescale 1ns/1ps
module crcp_top_bench;
    localparam logic [31:0] PV = 32'h1edc_6f41;
    localparam logic [31:0] SV = 32'h1234_5678;
    localparam logic [31:0] DV = 32'h3132_3334;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, crc_busy, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, ex;
    logic [3:0] pstrb;
    int n_fail = 0;
    int checks_done = 0;
    always #10 clk = ~clk;
    crcp_top dut_u (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .crc_busy(crc_busy));
    crcp_apb_master mst_u (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb));
    task automatic close_out();
        if (n_fail == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    function automatic logic [31:0] ref_sum(input logic [6:0] m, input logic [31:0] p,
            input logic [31:0] a, input logic [31:0] d, input int n);
        int w;
        logic [7:0] b;
        logic [15:0] h;
        logic [31:0] pl;
        logic [31:0] r;
        pl = m[1:0] == 2'h0 ? crcp_pkg::CRCP_POLY_CCITT : m[1:0] == 2'h1 ?
            crcp_pkg::CRCP_POLY_16 : m[1:0] == 2'h2 ? crcp_pkg::CRCP_POLY_32 : p;
        w = (m[1:0] < 2'h2 || (m[1:0] == 2'h3 && m[6])) ? 16 : 32;
        if (w == 16) a = a & crcp_pkg::CRCP_MASK_16;
        for (int k = 0; k < n; k++) begin
            b = d[8*k +: 8];
            if (m[2]) b = {<<{b}};
            if (m[3]) b = ~b;
            for (int i = 7; i >= 0; i--) a = (a << 1) ^ ((a[w-1] ^ b[i]) ? pl : 32'h0000_0000);
        end
        if (w == 16) a = a & crcp_pkg::CRCP_MASK_16;
        h = {<<{a[15:0]}};
        r = {<<{a}};
        if (m[4]) a = w == 16 ? {16'h0000, h} : r;
        if (m[5]) a = w == 16 ? a ^ crcp_pkg::CRCP_MASK_16 : ~a;
        return a;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
            input bit more = 1'b0);
        mst_u.xfer(1'b1, a, d, s, more, rd, err);
    endtask
    task automatic rdr(input logic [7:0] a);
        mst_u.xfer(1'b0, a, 32'h0000_0000, 4'h0, 1'b0, rd, err);
    endtask
    task automatic run(input logic [6:0] m);
        wr(crcp_pkg::CRCP_MODE_OFS, {25'h000_0000, m});
        wr(crcp_pkg::CRCP_POLY_OFS, PV);
        wr(crcp_pkg::CRCP_SEED_OFS, SV);
        wr(crcp_pkg::CRCP_DATA_OFS, DV);
        rdr(crcp_pkg::CRCP_SUM_OFS);
        ex = ref_sum(m, PV, SV, DV, 4);
    endtask
    task automatic t_reset();
        rdr(crcp_pkg::CRCP_MODE_OFS);
        cmp("mode", {25'h000_0000, crcp_pkg::CRCP_MODE_RST}, rd);
        rdr(crcp_pkg::CRCP_POLY_OFS);
        cmp("poly", crcp_pkg::CRCP_POLY_RST, rd);
    endtask
    task automatic t_fixed();
        for (int k = 0; k < 3; k++) begin
            run(7'(k));
            cmp("fixed sum", ex, rd);
        end
    endtask
    task automatic t_opts();
        logic [6:0] ms [4] = '{7'h3e, 7'h05, 7'h28, 7'h11};
        foreach (ms[k]) begin
            run(ms[k]);
            cmp("option sum", ex, rd);
        end
    endtask
    task automatic t_prog();
        run(7'h43);
        cmp("prog16 sum", ex, rd);
        run(7'h03);
        cmp("prog32 sum", ex, rd);
    endtask
    task automatic t_b2b();
        wr(crcp_pkg::CRCP_MODE_OFS, 32'h0000_0000);
        wr(crcp_pkg::CRCP_SEED_OFS, 32'h0000_1d0f);
        wr(crcp_pkg::CRCP_DATA_OFS, 32'h0000_00a5, 4'h1, 1'b1);
        wr(crcp_pkg::CRCP_DATA_OFS, 32'h0000_5a3c, 4'h3, 1'b1);
        wr(crcp_pkg::CRCP_DATA_OFS, DV, 4'hf, 1'b1);
        wr(crcp_pkg::CRCP_DATA_OFS, 32'h0000_00c3, 4'h1);
        rdr(crcp_pkg::CRCP_SUM_OFS);
        ex = ref_sum(7'h00, PV, 32'h0000_1d0f, 32'h0000_00a5, 1);
        ex = ref_sum(7'h00, PV, ex, 32'h0000_5a3c, 2);
        ex = ref_sum(7'h00, PV, ex, DV, 4);
        ex = ref_sum(7'h00, PV, ex, 32'h0000_00c3, 1);
        cmp("chain sum", ex, rd);
        wr(crcp_pkg::CRCP_SEED_OFS, 32'h0000_1d0f);
        wr(crcp_pkg::CRCP_DATA_OFS, 32'h0000_00a5, 4'h1);
        rdr(crcp_pkg::CRCP_SUM_OFS);
        ex = ref_sum(7'h00, PV, 32'h0000_1d0f, 32'h0000_00a5, 1);
        cmp("reseed sum", ex, rd);
    endtask
    task automatic t_lanes();
        logic [3:0] ss [4] = '{4'hc, 4'h8, 4'h4, 4'h2};
        logic [4:0] sh [4] = '{5'h10, 5'h18, 5'h10, 5'h08};
        wr(crcp_pkg::CRCP_SEED_OFS, SV);
        ex = SV;
        foreach (ss[k]) begin
            wr(crcp_pkg::CRCP_DATA_OFS, DV, ss[k], 1'b1);
            ex = ref_sum(7'h00, PV, ex, DV >> sh[k], ss[k] == 4'hc ? 2 : 1);
        end
        rdr(crcp_pkg::CRCP_CNT_OFS);
        cmp("lane count", 32'h0000_0005, rd);
        rdr(crcp_pkg::CRCP_SUM_OFS);
        cmp("lane sum", ex, rd);
    endtask
    task automatic t_err();
        wr(crcp_pkg::CRCP_DATA_OFS, DV, 4'h5);
        cmp("strobe err", 32'h0000_0001, {31'h0000_0000, err});
        rdr(crcp_pkg::CRCP_SUM_OFS);
        cmp("kept sum", ex, rd);
        rdr(8'h40);
        cmp("unmapped err", 32'h0000_0001, {31'h0000_0000, err});
        cmp("unmapped data", 32'h0000_0000, rd);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_fixed();
        t_opts();
        t_prog();
        t_b2b();
        t_lanes();
        t_err();
        close_out();
    end
    initial begin
        #200000;
        n_fail++;
        close_out();
    end
endmodule

// ---- verification/crcp_top_sva.sv ----
`timescale 1ns/1ps
module crcp_top_sva (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic crc_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire acc = psel && penable && pready && pwrite;
    wire dwr = acc && paddr == crcp_pkg::CRCP_DATA_OFS;
    a_word_busy_span: assert property (
        dwr && pstrb == 4'hf |=> crc_busy [*3] ##1 !crc_busy) else $error("word busy span");
    a_half_busy_span: assert property (
        dwr && pstrb == 4'h3 |=> crc_busy ##1 !crc_busy) else $error("half busy span");
    a_upper_half_span: assert property (
        dwr && pstrb == 4'hc |=> crc_busy ##1 !crc_busy) else $error("upper half busy span");
    a_byte_one_cycle: assert property (
        dwr && pstrb == 4'h1 |=> !crc_busy) else $error("byte left busy");
    a_busy_holds_ready: assert property (
        crc_busy |-> !pready) else $error("ready while busy");
    a_idle_ready_now: assert property (
        psel && penable && !crc_busy && $past(!crc_busy) && $past(rstn) |-> pready)
        else $error("idle access stalled");
    a_ready_after_drain: assert property (
        $fell(crc_busy) |-> !pready ##1 (!(psel && penable) || pready))
        else $error("drain gap wrong");
    a_bad_strobe_err: assert property (
        dwr && pstrb == 4'h5 |-> pslverr) else $error("bad strobe accepted");
    a_busy_has_cause: assert property (
        $rose(crc_busy) |-> $past(dwr) && $past(pstrb) != 4'h1) else $error("busy without write");
    c_word: cover property (dwr && pstrb == 4'hf);
    c_half: cover property (dwr && pstrb == 4'h3);
    c_err: cover property (pready && pslverr);
    c_upper: cover property (dwr && pstrb == 4'hc);
endmodule
bind crcp_top crcp_top_sva chk_u (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .crc_busy(crc_busy));
